// ---- rtl/csc_defines.svh ----
// Offsets, field positions, reset values and counts for core system control
`ifndef CSC_DEFINES_SVH
`define CSC_DEFINES_SVH

// Register byte offsets on the APB
`define CSC_AUX1_OFF   8'h00
`define CSC_DPTR0_OFF  8'h04
`define CSC_DPTR1_OFF  8'h08
`define CSC_ACC_OFF    8'h0C
`define CSC_OPB_OFF    8'h10
`define CSC_PSW_OFF    8'h14
`define CSC_SP_OFF     8'h18
`define CSC_DFADR_OFF  8'h1C
`define CSC_DFDAT_OFF  8'h20
`define CSC_DFCON_OFF  8'h24
`define CSC_PWR_OFF    8'h28
`define CSC_CMD_OFF    8'h2C
`define CSC_STAT_OFF   8'h30

// Field positions
`define CSC_AUX1_DPS   0
`define CSC_PSW_CY     7
`define CSC_PSW_AC     6
`define CSC_PSW_F0     5
`define CSC_PSW_RS1    4
`define CSC_PSW_RS0    3
`define CSC_PSW_OV     2
`define CSC_PSW_F1     1
`define CSC_PSW_P      0
`define CSC_PWR_IDLE   0
`define CSC_PWR_PD     1
`define CSC_DFCON_GO   0

// Reset values and the byte read from unimplemented space
`define CSC_SP_RST     8'h07
`define CSC_PSW_RST    8'h00
`define CSC_UNIMP_BYTE 8'hFF

// Data flash window seen by the code read
`define CSC_DF_BASE    16'hFC00

// Timing: clocks per machine cycle, machine cycles of reset low
`define CSC_CLK_PER_MC 4
`define CSC_RST_MC     2
`define CSC_RST_CLKS   (`CSC_CLK_PER_MC * `CSC_RST_MC)

`endif

// ---- rtl/csc_pkg.sv ----
// Types shared by the core system control design
package csc_pkg;
  // Sequencer states
  typedef enum logic [1:0] {
    CSC_ST_IDLE,
    CSC_ST_POP,
    CSC_ST_CODE
  } csc_state_t;

  // Command codes written to the command register
  typedef enum logic [2:0] {
    CSC_OP_PUSH = 3'h0,
    CSC_OP_POP  = 3'h1,
    CSC_OP_CODE_MEMORY_READ_INSTR = 3'h2,
    CSC_OP_MUL  = 3'h3,
    CSC_OP_DIV  = 3'h4
  } csc_op_t;

  // Byte and pointer widths
  typedef logic [7:0]  csc_byte_t;
  typedef logic [15:0] csc_ptr_t;
endpackage

// ---- rtl/csc_mem.sv ----
// Small byte memory with registered read data
`timescale 1ns/100ps
module csc_mem #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  input  wire logic          pclk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata_q
);
  logic [DW-1:0] mem_q [0:(1<<AW)-1]; // Storage array

  // Write port
  always_ff @(posedge pclk)
  begin
    if (we)
    begin
      mem_q[waddr] <= wdata;
    end
  end

  // Registered read port
  always_ff @(posedge pclk)
  begin
    rdata_q <= mem_q[raddr];
  end
endmodule

// ---- rtl/csc_top.sv ----
// Core system control: reset pin, clock gating, pointers, stack, flash paths
// Notes on behaviour
// - Reset only after pin low two machine cycles
// - Two 16-bit pointers, select bit chooses active
// - Idle stops CPU clock, peripherals keep running
// - Power-down stops every internal clock
// - Instructions fetched from program flash at zero
// - Code read fetches program flash bytes as data
// - Data flash read by code read, written via registers
// - Operand register feeds multiply and divide
// - Status word holds ALU flags and bank select
// - Eight-bit stack pointer into scratch-pad RAM
// - Pointer resets 07h, pre-increment push, post-decrement pop
// - Bank select picks one of four banks
`timescale 1ns/100ps
`include "csc_defines.svh"
module csc_top #(
  parameter int CODE_BYTES = 8192,
  parameter int CODE_AW    = 13
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              rst_pin_n,
  input  wire logic              fetch_req,
  input  wire csc_pkg::csc_ptr_t fetch_addr,
  output csc_pkg::csc_byte_t     fetch_data_q,
  output logic                   fetch_valid_q,
  output logic [CODE_AW-1:0]     pflash_addr_q,
  output logic                   pflash_rd_q,
  input  wire csc_pkg::csc_byte_t pflash_rdata,
  output logic                   cpu_clk_en_q,
  output logic                   periph_clk_en_q,
  output logic                   machine_tick_q,
  output logic                   core_reset_q,
  output logic [4:0]             bank_base_q
);
  import csc_pkg::*;

  // Reset pin synchroniser and low counter
  logic       pin_s1_q;      // First synchroniser stage
  logic       pin_s2_q;      // Second synchroniser stage
  logic [3:0] low_cnt_q;     // Clocks seen with pin low
  logic [3:0] low_cnt_d;
  logic       soft_rst;      // Architectural reset from the pin

  // Architectural registers
  logic      dps_q;          // Active pointer select
  csc_ptr_t  data_pointer_q [2];     // Two data pointers
  csc_byte_t acc_q;          // Accumulator
  csc_byte_t opb_q;          // Second operand register
  logic [7:1] psw_q;         // Status word, parity computed
  csc_byte_t sp_q;           // Stack top pointer
  csc_byte_t dfadr_q;        // Data flash address
  csc_byte_t dfdat_q;        // Data flash write data
  logic      idle_q;         // Idle request
  logic      pd_q;           // Power-down request
  csc_state_t st_q;          // Sequencer state
  csc_state_t st_d;
  logic      code_df_q;      // Pending code read targets data flash
  logic      code_oob_q;     // Pending code read outside both memories
  logic [1:0] div_q;         // Machine cycle divider
  logic      fetch_pend_q;   // Fetch waiting for flash data
  logic      fetch_oob_q;    // Fetch beyond the flash

  // Bus decode
  wire       acc_phase = psel & penable;
  wire       bus_done  = acc_phase & pready;
  wire       busy      = (st_q != CSC_ST_IDLE);
  wire       wr_en     = bus_done & pwrite & ~busy;
  wire       hit_aux   = (paddr == `CSC_AUX1_OFF);
  wire       hit_dp0   = (paddr == `CSC_DPTR0_OFF);
  wire       hit_dp1   = (paddr == `CSC_DPTR1_OFF);
  wire       hit_acc   = (paddr == `CSC_ACC_OFF);
  wire       hit_opb   = (paddr == `CSC_OPB_OFF);
  wire       hit_psw   = (paddr == `CSC_PSW_OFF);
  wire       hit_sp    = (paddr == `CSC_SP_OFF);
  wire       hit_dfa   = (paddr == `CSC_DFADR_OFF);
  wire       hit_dfd   = (paddr == `CSC_DFDAT_OFF);
  wire       hit_dfc   = (paddr == `CSC_DFCON_OFF);
  wire       hit_pwr   = (paddr == `CSC_PWR_OFF);
  wire       hit_cmd   = (paddr == `CSC_CMD_OFF);
  wire       hit_stat  = (paddr == `CSC_STAT_OFF);
  wire       hit_any   = hit_aux | hit_dp0 | hit_dp1 | hit_acc | hit_opb | hit_psw
                       | hit_sp | hit_dfa | hit_dfd | hit_dfc | hit_pwr | hit_cmd
                       | hit_stat;
  wire       bad_acc   = ~hit_any | (pwrite & busy);
  wire [2:0] cmd_code  = pwdata[2:0];
  wire       cmd_wr    = wr_en & hit_cmd;
  wire       do_push   = cmd_wr & (cmd_code == CSC_OP_PUSH);
  wire       do_pop    = cmd_wr & (cmd_code == CSC_OP_POP);
  wire       do_code_memory_read_instr   = cmd_wr & (cmd_code == CSC_OP_CODE_MEMORY_READ_INSTR);
  wire       do_mul    = cmd_wr & (cmd_code == CSC_OP_MUL);
  wire       do_div    = cmd_wr & (cmd_code == CSC_OP_DIV);

  // Derived status
  wire       parity    = ^acc_q;
  wire [7:0] psw_rd    = {psw_q, parity};
  wire [1:0] bank_sel  = {psw_q[`CSC_PSW_RS1], psw_q[`CSC_PSW_RS0]};
  csc_ptr_t  data_pointer_act;
  assign data_pointer_act = data_pointer_q[dps_q];

  // Arithmetic with the second operand
  wire [15:0] product  = acc_q * opb_q;
  wire        div_zero = (opb_q == 8'h00);
  wire [7:0]  quot     = div_zero ? `CSC_UNIMP_BYTE : acc_q / opb_q;
  wire [7:0]  remd     = div_zero ? acc_q : acc_q % opb_q;

  // Stack addresses
  wire [7:0] sp_inc    = sp_q + 8'h01;
  wire [7:0] sp_dec    = sp_q - 8'h01;

  // Code read address: accumulator plus active pointer
  csc_ptr_t  code_addr;
  assign code_addr = data_pointer_act + {8'h00, acc_q};
  wire       code_in_pf = (code_addr < CODE_BYTES[15:0]);
  wire       code_in_df = (code_addr[15:8] == 8'(`CSC_DF_BASE >> 8));

  // Memory connections
  csc_byte_t ram_rdata;      // Scratch-pad RAM read data
  csc_byte_t df_rdata;       // Data flash read data
  wire       df_we     = wr_en & hit_dfc & pwdata[`CSC_DFCON_GO];

  // Program flash port sharing: code read wins over fetch
  wire       fetch_ok  = fetch_req & cpu_clk_en_q & ~do_code_memory_read_instr;
  wire       fetch_pf  = fetch_ok & (fetch_addr < CODE_BYTES[15:0]);

  // Reset pin qualification
  assign soft_rst = (low_cnt_q == 4'(`CSC_RST_CLKS));

  // Scratch-pad RAM holding the stack
  csc_mem #(.AW(8), .DW(8)) u_ram (
    .pclk    (pclk),
    .we      (do_push),
    .waddr   (sp_inc),
    .wdata   (acc_q),
    .raddr   (sp_q),
    .rdata_q (ram_rdata)
  );

  // Non-volatile data area
  csc_mem #(.AW(8), .DW(8)) u_df (
    .pclk    (pclk),
    .we      (df_we),
    .waddr   (dfadr_q),
    .wdata   (dfdat_q),
    .raddr   (code_addr[7:0]),
    .rdata_q (df_rdata)
  );

  // Two-stage synchroniser on the reset pin
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_s1_q <= 1'b1;
      pin_s2_q <= 1'b1;
    end
    else
    begin
      pin_s1_q <= rst_pin_n;
      pin_s2_q <= pin_s1_q;
    end
  end

  // Low counter saturates at the qualifying length
  always_comb
  begin
    if (pin_s2_q)
    begin
      low_cnt_d = 4'h0;
    end
    else if (soft_rst)
    begin
      low_cnt_d = low_cnt_q;
    end
    else
    begin
      low_cnt_d = low_cnt_q + 4'h1;
    end
  end

  // Counter and reset output
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      low_cnt_q    <= 4'h0;
      core_reset_q <= 1'b1;
    end
    else
    begin
      low_cnt_q    <= low_cnt_d;
      core_reset_q <= soft_rst;
    end
  end

  // Sequencer next state
  always_comb
  begin
    case (st_q)
      CSC_ST_IDLE:
      begin
        st_d = do_pop ? CSC_ST_POP : (do_code_memory_read_instr ? CSC_ST_CODE : CSC_ST_IDLE);
      end
      CSC_ST_POP:  st_d = CSC_ST_IDLE;
      CSC_ST_CODE: st_d = CSC_ST_IDLE;
      default:     st_d = CSC_ST_IDLE;
    endcase
  end

  // Sequencer state and pending code read target
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q       <= CSC_ST_IDLE;
      code_df_q  <= 1'b0;
      code_oob_q <= 1'b0;
    end
    else if (soft_rst)
    begin
      st_q       <= CSC_ST_IDLE;
      code_df_q  <= 1'b0;
      code_oob_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      if (do_code_memory_read_instr)
      begin
        code_df_q  <= ~code_in_pf & code_in_df;
        code_oob_q <= ~code_in_pf & ~code_in_df;
      end
    end
  end

  // Pointer select, pointers and data flash registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dps_q     <= 1'b0;
      data_pointer_q[0] <= 16'h0000;
      data_pointer_q[1] <= 16'h0000;
      dfadr_q   <= 8'h00;
      dfdat_q   <= 8'h00;
    end
    else if (soft_rst)
    begin
      dps_q     <= 1'b0;
      data_pointer_q[0] <= 16'h0000;
      data_pointer_q[1] <= 16'h0000;
      dfadr_q   <= 8'h00;
      dfdat_q   <= 8'h00;
    end
    else if (wr_en)
    begin
      if (hit_aux) dps_q <= pwdata[`CSC_AUX1_DPS];
      if (hit_dp0) data_pointer_q[0] <= pwdata[15:0];
      if (hit_dp1) data_pointer_q[1] <= pwdata[15:0];
      if (hit_dfa) dfadr_q <= pwdata[7:0];
      if (hit_dfd) dfdat_q <= pwdata[7:0];
    end
  end

  // Accumulator and second operand: bus writes and command results
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acc_q <= 8'h00;
      opb_q <= 8'h00;
    end
    else if (soft_rst)
    begin
      acc_q <= 8'h00;
      opb_q <= 8'h00;
    end
    else if (st_q == CSC_ST_POP)
    begin
      acc_q <= ram_rdata;
    end
    else if (st_q == CSC_ST_CODE)
    begin
      // Program flash, data flash, or unimplemented space reads high
      acc_q <= code_oob_q ? `CSC_UNIMP_BYTE : (code_df_q ? df_rdata : pflash_rdata);
    end
    else if (do_mul)
    begin
      acc_q <= product[7:0];
      opb_q <= product[15:8];
    end
    else if (do_div)
    begin
      acc_q <= quot;
      opb_q <= remd;
    end
    else if (wr_en)
    begin
      if (hit_acc) acc_q <= pwdata[7:0];
      if (hit_opb) opb_q <= pwdata[7:0];
    end
  end

  // Status word: overflow and carry from multiply and divide
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      psw_q <= 7'(`CSC_PSW_RST >> 1);
    end
    else if (soft_rst)
    begin
      psw_q <= 7'(`CSC_PSW_RST >> 1);
    end
    else if (do_mul | do_div)
    begin
      psw_q[`CSC_PSW_CY] <= 1'b0;
      psw_q[`CSC_PSW_OV] <= do_mul ? (product[15:8] != 8'h00) : div_zero;
    end
    else if (wr_en & hit_psw)
    begin
      psw_q <= pwdata[7:1];
    end
  end

  // Stack pointer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sp_q <= `CSC_SP_RST;
    end
    else if (soft_rst)
    begin
      sp_q <= `CSC_SP_RST;
    end
    else if (do_push)
    begin
      sp_q <= sp_inc;
    end
    else if (st_q == CSC_ST_POP)
    begin
      sp_q <= sp_dec;
    end
    else if (wr_en & hit_sp)
    begin
      sp_q <= pwdata[7:0];
    end
  end

  // Power mode requests; pin reset wakes the device
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      idle_q <= 1'b0;
      pd_q   <= 1'b0;
    end
    else if (soft_rst)
    begin
      idle_q <= 1'b0;
      pd_q   <= 1'b0;
    end
    else if (wr_en & hit_pwr)
    begin
      idle_q <= pwdata[`CSC_PWR_IDLE];
      pd_q   <= pwdata[`CSC_PWR_PD];
    end
  end

  // Machine cycle divider and clock enables
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_q           <= 2'h0;
      machine_tick_q  <= 1'b0;
      cpu_clk_en_q    <= 1'b0;
      periph_clk_en_q <= 1'b0;
    end
    else
    begin
      div_q           <= pd_q ? 2'h0 : div_q + 2'h1;
      machine_tick_q  <= ~pd_q & (div_q == 2'(`CSC_CLK_PER_MC - 1));
      cpu_clk_en_q    <= ~idle_q & ~pd_q & ~soft_rst;
      periph_clk_en_q <= ~pd_q;
    end
  end

  // Program flash port and instruction fetch return
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pflash_rd_q   <= 1'b0;
      pflash_addr_q <= '0;
      fetch_pend_q  <= 1'b0;
      fetch_oob_q   <= 1'b0;
      fetch_valid_q <= 1'b0;
      fetch_data_q  <= 8'h00;
    end
    else
    begin
      pflash_rd_q  <= fetch_pf | (do_code_memory_read_instr & code_in_pf);
      if (do_code_memory_read_instr)
      begin
        pflash_addr_q <= code_addr[CODE_AW-1:0];
      end
      else if (fetch_pf)
      begin
        pflash_addr_q <= fetch_addr[CODE_AW-1:0];
      end
      fetch_pend_q  <= fetch_ok;
      fetch_oob_q   <= fetch_ok & ~fetch_pf;
      fetch_valid_q <= fetch_pend_q;
      if (fetch_pend_q)
      begin
        fetch_data_q <= fetch_oob_q ? `CSC_UNIMP_BYTE : pflash_rdata;
      end
    end
  end

  // APB answer: one wait state, read data and error with ready
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (hit_aux)  rd_mux = {31'h0, dps_q};
    if (hit_dp0)  rd_mux = {16'h0, data_pointer_q[0]};
    if (hit_dp1)  rd_mux = {16'h0, data_pointer_q[1]};
    if (hit_acc)  rd_mux = {24'h0, acc_q};
    if (hit_opb)  rd_mux = {24'h0, opb_q};
    if (hit_psw)  rd_mux = {24'h0, psw_rd};
    if (hit_sp)   rd_mux = {24'h0, sp_q};
    if (hit_dfa)  rd_mux = {24'h0, dfadr_q};
    if (hit_dfd)  rd_mux = {24'h0, dfdat_q};
    if (hit_pwr)  rd_mux = {30'h0, pd_q, idle_q};
    if (hit_stat) rd_mux = {20'h0, bank_sel, core_reset_q, busy, ram_rdata};
  end

  // Bus response registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= acc_phase & ~pready;
      pslverr <= acc_phase & ~pready & bad_acc;
      if (acc_phase & ~pready)
      begin
        prdata <= (pwrite | ~hit_any) ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  // Working bank base address in scratch-pad RAM
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bank_base_q <= 5'h00;
    end
    else
    begin
      bank_base_q <= {bank_sel, 3'h0};
    end
  end
endmodule

// ---- verif/csc_chk_sva.sv ----
// Port checker for core system control, bound to its top
`timescale 1ns/100ps
`include "csc_defines.svh"
module csc_chk #(
  parameter int CODE_BYTES = 8192,
  parameter int CODE_AW    = 13
) (
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [7:0]         paddr,
  input wire logic [31:0]        pwdata,
  input wire logic               pready,
  input wire logic               pslverr,
  input wire logic               rst_pin_n,
  input wire logic               fetch_req,
  input wire csc_pkg::csc_ptr_t  fetch_addr,
  input wire csc_pkg::csc_byte_t fetch_data_q,
  input wire logic               fetch_valid_q,
  input wire logic [CODE_AW-1:0] pflash_addr_q,
  input wire logic               pflash_rd_q,
  input wire csc_pkg::csc_byte_t pflash_rdata,
  input wire logic               cpu_clk_en_q,
  input wire logic               periph_clk_en_q,
  input wire logic               machine_tick_q,
  input wire logic               core_reset_q,
  input wire logic [4:0]         bank_base_q
);
  import csc_pkg::*;
  wire        acc_w  = psel & penable & pready & pwrite;     // Write taken
  wire        cmd_go = acc_w & (paddr == `CSC_CMD_OFF);    // Command issued
  wire        wr_psw = acc_w & ~pslverr & ~core_reset_q & (paddr == `CSC_PSW_OFF);
  logic [1:0] bsel_q;                                        // Bank last written
  // Keep the bank field of each accepted status write
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      bsel_q <= 2'h0;
    else if (wr_psw)
      bsel_q <= pwdata[4:3];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Bus phases
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence one_wait_s;
    !pready ##1 pready;
  endsequence
  apb_wait_a: assert property (setup_s |=> one_wait_s)
    else $error("bus answer not after one wait state");
  pin_qual_a: assert property (
    $rose(core_reset_q) |-> !$past(rst_pin_n, 4) && !$past(rst_pin_n, 9))
    else $error("core reset without a long pin low");
  pd_cpu_a: assert property (!periph_clk_en_q |-> !cpu_clk_en_q)
    else $error("cpu clock runs in power-down");
  pd_tick_a: assert property (
    !periph_clk_en_q && !$past(periph_clk_en_q) |-> !machine_tick_q)
    else $error("tick in power-down");
  tick_gap_a: assert property (machine_tick_q |=> !machine_tick_q [*3])
    else $error("machine cycle shorter than four clocks");
  fetch_issue_a: assert property (
    fetch_req && cpu_clk_en_q && !cmd_go && fetch_addr < CODE_BYTES |=>
    pflash_rd_q && pflash_addr_q == $past(fetch_addr[CODE_AW-1:0]))
    else $error("fetch not sent to program flash");
  fetch_valid_a: assert property (fetch_valid_q |->
    $past(fetch_req, 2) && $past(cpu_clk_en_q, 2) &&
    ($past(pflash_rd_q) || $past(fetch_addr, 2) >= CODE_BYTES))
    else $error("fetch answer without flash read");
  fetch_data_a: assert property (fetch_valid_q |-> fetch_data_q ==
    ($past(fetch_addr, 2) < CODE_BYTES ? $past(pflash_rdata) : 8'hFF))
    else $error("fetched byte wrong");
  bank_map_a: assert property ($past(wr_psw, 2) |-> bank_base_q == {bsel_q, 3'h0})
    else $error("bank base does not follow status word");
  bank_align_a: assert property (bank_base_q[2:0] == 3'h0)
    else $error("bank base not a multiple of eight");
endmodule
bind csc_top csc_chk #(.CODE_BYTES(CODE_BYTES), .CODE_AW(CODE_AW)) csc_chk_inst (.*);

// ---- verif/csc_flash_model.sv ----
// Program flash model answering the design's read strobe
`timescale 1ns/100ps
module csc_flash_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        pflash_rd_q,
  input  wire logic [12:0] pflash_addr_q,
  output csc_pkg::csc_byte_t pflash_rdata
);
  import csc_pkg::*;
  csc_byte_t   last_d; // Last byte handed out
  // Remember the byte given with each strobe
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      last_d <= 8'h00;
    else if (pflash_rd_q)
      last_d <= pflash_rdata;
  // Valid in the strobe's own cycle, where the design takes it; otherwise inverted junk
  assign pflash_rdata = pflash_rd_q ?
    (pflash_addr_q[7:0] ^ {3'h0, pflash_addr_q[12:8]} ^ 8'h3C) : ~last_d;
endmodule

// ---- verif/tb_top.sv ----
// Self-checking bench for core system control
`timescale 1ns/100ps
`include "csc_defines.svh"
module tb_top;
  import csc_pkg::*;
  typedef struct {logic w; logic [7:0] a; logic [31:0] d, x; logic er;} csc_row_t;
  logic        pclk, presetn, psel, penable, pwrite, rst_pin_n, fetch_req, e, v;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic        pready, pslverr, fetch_valid_q, pflash_rd_q, core_reset_q;
  logic        cpu_clk_en_q, periph_clk_en_q, machine_tick_q;
  logic [12:0] pflash_addr_q;
  logic [4:0]  bank_base_q;
  csc_ptr_t    fetch_addr;
  csc_byte_t   fetch_data_q, pflash_rdata, fd;
  int          fails, samples_checked, cyc, k;
  csc_ptr_t    fa [4] = '{16'h0000, 16'h0ABC, 16'h1FFF, 16'h2000}; // Fetch addresses
  csc_row_t    rows [14] = '{'{0, 8'h18, 0, 32'h07, 0}, '{0, 8'h14, 0, 0, 0},
    '{1, 8'h0C, 32'h34, 0, 0}, '{0, 8'h14, 0, 32'h01, 0}, '{1, 8'h10, 32'hA5, 0, 0},
    '{0, 8'h10, 0, 32'hA5, 0}, '{1, 8'h04, 32'hABCD1234, 0, 0}, '{0, 8'h04, 0, 32'h1234, 0},
    '{1, 8'h08, 32'hFC10, 0, 0}, '{0, 8'h08, 0, 32'hFC10, 0}, '{1, 8'h00, 32'h1, 0, 0},
    '{0, 8'h00, 0, 32'h1, 0}, '{0, 8'h40, 0, 0, 1}, '{1, 8'h40, 32'h5, 0, 1}};
  csc_top csc_top_inst (.*);
  csc_flash_model csc_flash_model_inst (.*);
  // Clock
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // Hang guard
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      fails++;
      conclude();
    end
  end
  // Compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer held until pready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    fails += (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    check(r, x);
  endtask
  // Expected program flash byte
  function automatic csc_byte_t fb(input logic [15:0] a);
    return a[7:0] ^ {3'h0, a[12:8]} ^ 8'h3C;
  endfunction
  // Multiply or divide, then check both operands and status
  task automatic arith(input csc_byte_t a, b, input csc_op_t op, input csc_byte_t ea, eb, ep);
    wr(8'h0C, {24'h0, a});
    wr(8'h10, {24'h0, b});
    wr(8'h2C, {29'h0, op});
    rdc(8'h0C, {24'h0, ea});
    rdc(8'h10, {24'h0, eb});
    rdc(8'h14, {24'h0, ep});
  endtask
  // Code read with a given accumulator
  task automatic code_memory_read_instr(input csc_byte_t acc, x);
    wr(8'h0C, {24'h0, acc});
    wr(8'h2C, {29'h0, CSC_OP_CODE_MEMORY_READ_INSTR});
    rdc(8'h0C, {24'h0, x});
  endtask
  // One fetch request, byte collected if it comes
  task automatic fetch(input csc_ptr_t a);
    @(posedge pclk);
    fetch_req  <= 1'b1;
    fetch_addr <= a;
    @(posedge pclk);
    fetch_req <= 1'b0;
    v = 1'b0;
    for (int n = 0; n < 6 && !v; n++)
    begin
      @(negedge pclk);
      v = (fetch_valid_q === 1'b1);
    end
    fd = fetch_data_q;
  endtask
  // Count machine ticks over twelve clocks
  task automatic ticks();
    k = 0;
    repeat (12) @(negedge pclk) k += (machine_tick_q === 1'b1);
  endtask
  task automatic pin_low(input int n);
    @(posedge pclk);
    rst_pin_n <= 1'b0;
    repeat (n) @(posedge pclk);
    rst_pin_n <= 1'b1;
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    {psel, penable, pwrite, fetch_req, presetn, rst_pin_n} = 6'h01;
    {paddr, pwdata, fetch_addr} = 56'h0;
    {fails, samples_checked, cyc} = 96'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i])
    begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      check(r, rows[i].x);
      check({31'h0, e}, {31'h0, rows[i].er});
    end
    wr(8'h0C, 32'h5C);
    wr(8'h2C, 32'h0);
    rdc(8'h18, 32'h08);
    rdc(8'h30, 32'h5C);
    wr(8'h0C, 32'h0);
    wr(8'h2C, 32'h1);
    rdc(8'h0C, 32'h5C);
    rdc(8'h18, 32'h07);
    wr(8'h18, 32'hFF);
    wr(8'h0C, 32'h77);
    wr(8'h2C, 32'h0);
    rdc(8'h18, 32'h00);
    rdc(8'h30, 32'h77);
    arith(8'h10, 8'h20, CSC_OP_MUL, 8'h00, 8'h02, 8'h04);
    arith(8'h0F, 8'h0E, CSC_OP_MUL, 8'hD2, 8'h00, 8'h00);
    arith(8'h64, 8'h07, CSC_OP_DIV, 8'h0E, 8'h02, 8'h01);
    arith(8'h5A, 8'h00, CSC_OP_DIV, 8'hFF, 8'h5A, 8'h04);
    wr(8'h1C, 32'h13);
    wr(8'h20, 32'h9E);
    wr(8'h24, 32'h1);
    wr(8'h00, 32'h1);
    code_memory_read_instr(8'h03, 8'h9E);
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h1FF0);
    code_memory_read_instr(8'h0F, fb(16'h1FFF));
    code_memory_read_instr(8'h10, 8'hFF);
    for (int b = 0; b < 4; b++)
    begin
      wr(8'h14, b << 3);
      repeat (2) @(negedge pclk);
      check({27'h0, bank_base_q}, b * 8);
      rdc(8'h30, {20'h0, b[1:0], 10'h077});
    end
    foreach (fa[i])
    begin
      fetch(fa[i]);
      check({31'h0, v}, 32'h1);
      check({24'h0, fd}, {24'h0, fa[i] < 16'h2000 ? fb(fa[i]) : 8'hFF});
    end
    wr(8'h28, 32'h1);
    repeat (2) @(negedge pclk);
    check({cpu_clk_en_q, periph_clk_en_q}, 2'b01);
    ticks();
    check(k, 3);
    fetch(16'h0010);
    check({31'h0, v}, 32'h0);
    wr(8'h28, 32'h2);
    repeat (2) @(negedge pclk);
    check({cpu_clk_en_q, periph_clk_en_q}, 2'b00);
    ticks();
    check(k, 0);
    wr(8'h28, 32'h0);
    repeat (2) @(negedge pclk);
    check({cpu_clk_en_q, periph_clk_en_q}, 2'b11);
    wr(8'h18, 32'h40);
    pin_low(`CSC_RST_CLKS - 1);
    k = 0;
    repeat (12) @(negedge pclk) k += (core_reset_q !== 1'b0);
    check(k, 0);
    rdc(8'h18, 32'h40);
    pin_low(`CSC_RST_CLKS + 6);
    @(negedge pclk);
    check({core_reset_q, cpu_clk_en_q}, 2'b10);
    for (k = 0; k < 10 && core_reset_q !== 1'b0; k++) @(negedge pclk);
    rdc(8'h18, 32'h07);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdc(8'h14, 32'h00);
    conclude();
  end
endmodule
